//--- rtl/cmx_pkg.sv
// Package: constants and types for the cache maintenance and translation block
// Function
// R1: Set/way way field is operand bits 31:30
// R2: Set index taken from operand bits S+4:5
// R3: S is 7, 8, 9 for 16/32/64KB
// R4: Line address ops ignore operand bits 4:0
// R5: Branch target entry flush ignores bits 2:0
// R6: Interrupted whole clean returns launch address plus 4
// R7: Whole cache ops resume where they stopped
// R8: User mode privileged op raises undefined trap
// R9: Translate true virtual address, store result
// R10: Translation privileged only, uses current space id
// R11: Minor c8 translates; opcode2 selects permission check
// R12: Result bit 0 flags aborted translation
// R13: Abort puts fault encoding in bits 5:1
// R14: Result read via minor c4, opcode2 0, privileged
// R15: Success: page 31:12, share 8, type 7:6
// R16: Normal memory inner attributes in bits 5:4
// R17: Normal memory outer attributes in bits 3:2
// R18: Way field is way, set is line
// R19: Line ops missing the cache do nothing
// R20: Result read stalls until translation completes
package cmx_pkg;

  // ==========================================================================
  // Instruction decode
  localparam logic [3:0] CRN_CACHE    = 4'h7;
  localparam logic [3:0] CRM_WFI      = 4'h0;
  localparam logic [3:0] CRM_RESULT   = 4'h4;
  localparam logic [3:0] CRM_ICACHE   = 4'h5;
  localparam logic [3:0] CRM_DCACHE   = 4'h6;
  localparam logic [3:0] CRM_BOTH     = 4'h7;
  localparam logic [3:0] CRM_XLATE    = 4'h8;
  localparam logic [3:0] CRM_CLEAN    = 4'ha;
  localparam logic [3:0] CRM_CLEANINV = 4'he;
  localparam logic [2:0] OP2_WHOLE    = 3'h0;
  localparam logic [2:0] OP2_MVA      = 3'h1;
  localparam logic [2:0] OP2_SETWAY   = 3'h2;
  localparam logic [2:0] OP2_FLUSHPF  = 3'h4;
  localparam logic [2:0] OP2_DMB      = 3'h5;
  localparam logic [2:0] OP2_BTC_ALL  = 3'h6;
  localparam logic [2:0] OP2_BTC_ONE  = 3'h7;
  localparam logic [2:0] OP2_RESULT   = 3'h0;
  localparam logic [2:0] OP2_PERM_MAX = 3'h3;

  // ==========================================================================
  // Operand fields
  localparam int WAY_HI       = 31;
  localparam int WAY_LO       = 30;
  localparam int SET_LO       = 5;
  localparam int SET_SPAN     = 4;
  localparam int LINE_LSB     = 5;
  localparam int BTC_LSB      = 3;
  localparam logic [3:0] S_16K = 4'h7;
  localparam logic [3:0] S_32K = 4'h8;
  localparam logic [3:0] S_64K = 4'h9;
  localparam logic [31:0] RET_OFFSET = 32'h0000_0004;

  // ==========================================================================
  // Result register layout
  localparam int RES_ABORT    = 0;
  localparam int RES_FS_HI    = 5;
  localparam int RES_FS_LO    = 1;
  localparam int RES_PA_LO    = 12;
  localparam int RES_SHARE    = 8;
  localparam logic [31:0] RES_RESET = 32'h0000_0000;
  localparam logic [1:0] MT_NORMAL  = 2'h2;

  typedef enum logic [1:0] {
    CSZ_16K,
    CSZ_32K,
    CSZ_64K
  } cmx_size_type;

  typedef enum logic [2:0] {
    OPK_NONE,
    OPK_LINE_MVA,
    OPK_LINE_SW,
    OPK_WHOLE,
    OPK_BTC_ONE,
    OPK_OTHER
  } cmx_op_type;

endpackage : cmx_pkg

//--- rtl/cmx_xlate_if.sv
// Interface: translation request and answer between control and translator
`timescale 1ns/1ns
interface cmx_xlate_if;
  logic        req;
  logic [31:0] va;
  logic [1:0]  perm;
  logic [7:0]  address_space_id;
  logic        done;
  logic [31:0] result;

  modport ctl (output req, output va, output perm, output address_space_id,
               input done, input result);
  modport xl  (input req, input va, input perm, input address_space_id,
               output done, output result);
endinterface : cmx_xlate_if

//--- rtl/cmx_xlate.sv
// Module: forwards translation to the TLB port and formats the result word
`timescale 1ns/1ns
module cmx_xlate (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Control side
  cmx_xlate_if.xl          xif,
  // TLB lookup port
  output logic             tlb_req_o,
  output logic [31:0]      tlb_va_o,
  output logic [1:0]       tlb_perm_o,
  output logic [7:0]       tlb_address_space_id_o,
  input  wire logic        tlb_done_i,
  input  wire logic        tlb_abort_i,
  input  wire logic [4:0]  tlb_fault_i,
  input  wire logic [19:0] tlb_page_i,
  input  wire logic        tlb_share_i,
  input  wire logic [1:0]  tlb_type_i,
  input  wire logic [1:0]  tlb_inner_i,
  input  wire logic [1:0]  tlb_outer_i
);

  logic        busy_ff, nxt_busy;
  logic [31:0] res_ff, nxt_res;
  logic        done_ff, nxt_done;

  // ==========================================================================
  // Next state
  always_comb begin
    nxt_busy = busy_ff;
    nxt_res  = res_ff;
    nxt_done = 1'b0;
    if (xif.req) begin
      nxt_busy = 1'b1;
    end else if (busy_ff && tlb_done_i) begin
      nxt_busy = 1'b0;
      nxt_done = 1'b1;
      nxt_res  = cmx_pkg::RES_RESET;
      if (tlb_abort_i) begin
        nxt_res[cmx_pkg::RES_ABORT] = 1'b1; // R12
        nxt_res[cmx_pkg::RES_FS_HI:cmx_pkg::RES_FS_LO] = tlb_fault_i; // R13
      end else begin
        nxt_res[31:cmx_pkg::RES_PA_LO] = tlb_page_i; // R15
        nxt_res[cmx_pkg::RES_SHARE]    = tlb_share_i; // R15
        nxt_res[7:6]                   = tlb_type_i; // R15
        // Attributes only for normal memory
        if (tlb_type_i == cmx_pkg::MT_NORMAL) begin
          nxt_res[5:4] = tlb_inner_i; // R16
          nxt_res[3:2] = tlb_outer_i; // R17
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_ff <= 1'b0;
      res_ff  <= cmx_pkg::RES_RESET;
      done_ff <= 1'b0;
    end else begin
      busy_ff <= nxt_busy;
      res_ff  <= nxt_res;
      done_ff <= nxt_done;
    end
  end

  assign tlb_req_o  = busy_ff;
  assign tlb_va_o   = xif.va; // R9
  assign tlb_perm_o = xif.perm; // R11
  assign tlb_address_space_id_o = xif.address_space_id; // R10
  assign xif.done   = done_ff;
  assign xif.result = res_ff;

endmodule : cmx_xlate

//--- rtl/cmx_setway.sv
// Module: splits a set/way operand into way and set index by cache size
`timescale 1ns/1ns
module cmx_setway (
  // Configuration
  input  wire cmx_pkg::cmx_size_type size_i,
  // Operand
  input  wire logic [31:0]           opnd_i,
  // Decoded fields
  output logic [1:0]                 way_o,
  output logic [8:0]                 set_o,
  output logic [3:0]                 s_o
);

  logic [8:0] mask;

  always_comb begin
    case (size_i)
      cmx_pkg::CSZ_16K: s_o = cmx_pkg::S_16K; // R3
      cmx_pkg::CSZ_32K: s_o = cmx_pkg::S_32K; // R3
      default:          s_o = cmx_pkg::S_64K; // R3
    endcase
  end

  // Set field is S bits wide
  genvar b;
  for (b = 0; b < 9; b++) begin : g_mask
    assign mask[b] = (b < int'(s_o));
  end

  assign way_o = opnd_i[cmx_pkg::WAY_HI:cmx_pkg::WAY_LO]; // R1 R18
  assign set_o = opnd_i[cmx_pkg::SET_LO +: 9] & mask; // R2 R18

endmodule : cmx_setway

//--- rtl/cmx_top.sv
// Module: coprocessor cache maintenance operand decode and translation control
`timescale 1ns/1ns
module cmx_top (
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // Configuration
  input  wire cmx_pkg::cmx_size_type cache_size_i,
  input  wire logic [7:0]            address_space_id_i,
  // Coprocessor instruction port
  input  wire logic                  cp_valid_i,
  input  wire logic                  cp_write_i,
  input  wire logic                  cp_user_i,
  input  wire logic [3:0]            cp_crn_i,
  input  wire logic [3:0]            cp_crm_i,
  input  wire logic [2:0]            cp_op2_i,
  input  wire logic [31:0]           cp_wdata_i,
  input  wire logic [31:0]           cp_pc_i,
  output logic                       cp_stall_o,
  output logic                       cp_done_o,
  output logic                       cp_undef_o,
  output logic [31:0]                cp_rdata_o,
  // Interrupt abandon of whole-cache ops
  input  wire logic                  irq_take_i,
  output logic [31:0]                irq_link_o,
  // Cache maintenance port
  output logic                       cm_req_o,
  output cmx_pkg::cmx_op_type        cm_kind_o,
  output logic [3:0]                 cm_crm_o,
  output logic [31:0]                cm_addr_o,
  output logic [1:0]                 cm_way_o,
  output logic [8:0]                 cm_set_o,
  output logic [10:0]                cm_pos_o,
  input  wire logic                  cm_hit_i,
  input  wire logic                  cm_last_i,
  // TLB lookup port
  output logic                       tlb_req_o,
  output logic [31:0]                tlb_va_o,
  output logic [1:0]                 tlb_perm_o,
  output logic [7:0]                 tlb_address_space_id_o,
  input  wire logic                  tlb_done_i,
  input  wire logic                  tlb_abort_i,
  input  wire logic [4:0]            tlb_fault_i,
  input  wire logic [19:0]           tlb_page_i,
  input  wire logic                  tlb_share_i,
  input  wire logic [1:0]            tlb_type_i,
  input  wire logic [1:0]            tlb_inner_i,
  input  wire logic [1:0]            tlb_outer_i
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WHOLE,
    ST_XLATE
  } cmx_state_type;

  cmx_xlate_if xif ();

  cmx_state_type state_ff, nxt_state;
  logic [31:0]   res_ff, nxt_res;
  logic [10:0]   pos_ff, nxt_pos;
  logic [3:0]    wcrm_ff, nxt_wcrm;
  logic          xreq_ff, nxt_xreq;
  logic [31:0]   xva_ff, nxt_xva;
  logic [1:0]    xperm_ff, nxt_xperm;
  logic [31:0]   link_ff, nxt_link;
  logic          done_ff, nxt_done;
  logic          undef_ff, nxt_undef;
  logic [31:0]   rdata_ff, nxt_rdata;
  logic          lreq_ff, nxt_lreq;
  cmx_pkg::cmx_op_type kind_ff, nxt_kind;
  logic [31:0]   addr_ff, nxt_addr;
  logic [3:0]    lcrm_ff, nxt_lcrm;

  logic [1:0] sw_way;
  logic [8:0] sw_set;
  logic [3:0] sw_s;

  // ==========================================================================
  // Decode
  logic is_c7, user_ok, is_res_rd, is_xlate, is_whole, is_mva, is_sw, is_btc1;

  assign is_c7   = cp_valid_i && (cp_crn_i == cmx_pkg::CRN_CACHE);
  // User mode: barriers, prefetch flush
  assign user_ok = (cp_crm_i == cmx_pkg::CRM_ICACHE && cp_op2_i == cmx_pkg::OP2_FLUSHPF) ||
                   (cp_crm_i == cmx_pkg::CRM_CLEAN &&
                    (cp_op2_i == cmx_pkg::OP2_FLUSHPF || cp_op2_i == cmx_pkg::OP2_DMB));
  assign is_res_rd = !cp_write_i && cp_crm_i == cmx_pkg::CRM_RESULT &&
                     cp_op2_i == cmx_pkg::OP2_RESULT; // R14
  assign is_xlate  = cp_write_i && cp_crm_i == cmx_pkg::CRM_XLATE &&
                     cp_op2_i <= cmx_pkg::OP2_PERM_MAX; // R11
  assign is_whole  = cp_write_i && cp_op2_i == cmx_pkg::OP2_WHOLE &&
                     (cp_crm_i == cmx_pkg::CRM_ICACHE || cp_crm_i == cmx_pkg::CRM_DCACHE ||
                      cp_crm_i == cmx_pkg::CRM_BOTH || cp_crm_i == cmx_pkg::CRM_CLEAN ||
                      cp_crm_i == cmx_pkg::CRM_CLEANINV);
  assign is_mva    = cp_write_i && cp_op2_i == cmx_pkg::OP2_MVA &&
                     cp_crm_i != cmx_pkg::CRM_XLATE && cp_crm_i != cmx_pkg::CRM_WFI;
  assign is_sw     = cp_write_i && cp_op2_i == cmx_pkg::OP2_SETWAY &&
                     cp_crm_i != cmx_pkg::CRM_XLATE;
  assign is_btc1   = cp_write_i && cp_crm_i == cmx_pkg::CRM_ICACHE &&
                     cp_op2_i == cmx_pkg::OP2_BTC_ONE;

  cmx_setway u_setway (
    .size_i (cache_size_i),
    .opnd_i (cp_wdata_i),
    .way_o  (sw_way),
    .set_o  (sw_set),
    .s_o    (sw_s)
  );

  cmx_xlate u_xlate (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .xif         (xif),
    .tlb_req_o   (tlb_req_o),
    .tlb_va_o    (tlb_va_o),
    .tlb_perm_o  (tlb_perm_o),
    .tlb_address_space_id_o  (tlb_address_space_id_o),
    .tlb_done_i  (tlb_done_i),
    .tlb_abort_i (tlb_abort_i),
    .tlb_fault_i (tlb_fault_i),
    .tlb_page_i  (tlb_page_i),
    .tlb_share_i (tlb_share_i),
    .tlb_type_i  (tlb_type_i),
    .tlb_inner_i (tlb_inner_i),
    .tlb_outer_i (tlb_outer_i)
  );

  assign xif.req  = xreq_ff;
  assign xif.va   = xva_ff;
  assign xif.perm = xperm_ff;
  assign xif.address_space_id = address_space_id_i; // R10

  // ==========================================================================
  // Control state machine
  always_comb begin
    nxt_state = state_ff;
    nxt_res   = res_ff;
    nxt_pos   = pos_ff;
    nxt_wcrm  = wcrm_ff;
    nxt_xreq  = 1'b0;
    nxt_xva   = xva_ff;
    nxt_xperm = xperm_ff;
    nxt_link  = link_ff;
    nxt_done  = 1'b0;
    nxt_undef = 1'b0;
    nxt_rdata = rdata_ff;
    nxt_lreq  = 1'b0;
    nxt_kind  = kind_ff;
    nxt_addr  = addr_ff;
    nxt_lcrm  = lcrm_ff;
    if (xif.done) begin
      nxt_res = xif.result; // R9
    end
    case (state_ff)
      ST_IDLE: begin
        if (is_c7 && cp_user_i && !user_ok) begin
          nxt_undef = 1'b1; // R8 R10 R14
        end else if (is_c7 && is_res_rd) begin
          nxt_rdata = res_ff;
          nxt_done  = 1'b1;
        end else if (is_c7 && is_xlate) begin
          nxt_xreq  = 1'b1;
          nxt_xva   = cp_wdata_i; // R9
          nxt_xperm = cp_op2_i[1:0]; // R11
          nxt_state = ST_XLATE;
        end else if (is_c7 && is_whole) begin
          // Same op reissued resumes
          if (cp_crm_i != wcrm_ff) begin
            nxt_pos = '0; // R7
          end
          nxt_wcrm  = cp_crm_i;
          nxt_link  = cp_pc_i + cmx_pkg::RET_OFFSET; // R6
          nxt_state = ST_WHOLE;
        end else if (is_c7) begin
          nxt_done = 1'b1;
          nxt_lcrm = cp_crm_i;
          if (is_btc1) begin
            nxt_lreq = 1'b1;
            nxt_kind = cmx_pkg::OPK_BTC_ONE;
            nxt_addr = {cp_wdata_i[31:cmx_pkg::BTC_LSB], 3'h0}; // R5
          end else if (is_mva) begin
            nxt_lreq = 1'b1;
            nxt_kind = cmx_pkg::OPK_LINE_MVA;
            nxt_addr = {cp_wdata_i[31:cmx_pkg::LINE_LSB], 5'h00}; // R4
          end else if (is_sw) begin
            nxt_lreq = 1'b1;
            nxt_kind = cmx_pkg::OPK_LINE_SW;
            nxt_addr = cp_wdata_i;
          end else begin
            nxt_kind = cmx_pkg::OPK_OTHER;
          end
        end
      end
      ST_WHOLE: begin
        if (irq_take_i) begin
          nxt_state = ST_IDLE; // R6 R7
        end else if (cm_last_i) begin
          nxt_pos   = '0;
          nxt_wcrm  = cmx_pkg::CRM_WFI;
          nxt_done  = 1'b1;
          nxt_state = ST_IDLE;
        end else begin
          nxt_pos = pos_ff + 11'h001; // R7
        end
      end
      ST_XLATE: begin
        if (xif.done) begin
          nxt_done  = 1'b1;
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= ST_IDLE;
      res_ff   <= cmx_pkg::RES_RESET;
      pos_ff   <= '0;
      wcrm_ff  <= cmx_pkg::CRM_WFI;
      xreq_ff  <= 1'b0;
      xva_ff   <= '0;
      xperm_ff <= '0;
      link_ff  <= '0;
      done_ff  <= 1'b0;
      undef_ff <= 1'b0;
      rdata_ff <= '0;
      lreq_ff  <= 1'b0;
      kind_ff  <= cmx_pkg::OPK_NONE;
      addr_ff  <= '0;
      lcrm_ff  <= '0;
    end else begin
      state_ff <= nxt_state;
      res_ff   <= nxt_res;
      pos_ff   <= nxt_pos;
      wcrm_ff  <= nxt_wcrm;
      xreq_ff  <= nxt_xreq;
      xva_ff   <= nxt_xva;
      xperm_ff <= nxt_xperm;
      link_ff  <= nxt_link;
      done_ff  <= nxt_done;
      undef_ff <= nxt_undef;
      rdata_ff <= nxt_rdata;
      lreq_ff  <= nxt_lreq;
      kind_ff  <= nxt_kind;
      addr_ff  <= nxt_addr;
      lcrm_ff  <= nxt_lcrm;
    end
  end

  // ==========================================================================
  // Outputs
  // Stall makes a result read wait
  assign cp_stall_o = (state_ff != ST_IDLE); // R20
  assign cp_done_o  = done_ff;
  assign cp_undef_o = undef_ff;
  assign cp_rdata_o = rdata_ff;
  assign irq_link_o = link_ff; // R6
  // Cache drops misses itself
  assign cm_req_o   = lreq_ff || (state_ff == ST_WHOLE); // R19
  assign cm_kind_o  = (state_ff == ST_WHOLE) ? cmx_pkg::OPK_WHOLE : kind_ff;
  assign cm_crm_o   = (state_ff == ST_WHOLE) ? wcrm_ff : lcrm_ff;
  assign cm_addr_o  = addr_ff;
  assign cm_way_o   = addr_ff[cmx_pkg::WAY_HI:cmx_pkg::WAY_LO]; // R1
  assign cm_set_o   = sw_set_q(addr_ff, sw_s); // R2
  assign cm_pos_o   = pos_ff;

  function automatic logic [8:0] sw_set_q(input logic [31:0] a, input logic [3:0] s);
    logic [8:0] m;
    m = 9'h1ff >> (4'h9 - s);
    return a[cmx_pkg::SET_LO +: 9] & m;
  endfunction

  logic unused_ok;
  assign unused_ok = cm_hit_i ^ sw_way[0] ^ sw_set[0];

endmodule : cmx_top

//--- dv/cmx_props.sv
// Checker: port properties of the maintenance block
`timescale 1ns/1ns
module cmx_props (
  // Clock and reset
  input wire logic                  clk_i,
  input wire logic                  rst_i,
  // Configuration
  input wire cmx_pkg::cmx_size_type cache_size_i,
  input wire logic [7:0]            address_space_id_i,
  // Coprocessor port
  input wire logic                  cp_valid_i,
  input wire logic                  cp_write_i,
  input wire logic                  cp_user_i,
  input wire logic [3:0]            cp_crn_i,
  input wire logic [3:0]            cp_crm_i,
  input wire logic [2:0]            cp_op2_i,
  input wire logic [31:0]           cp_wdata_i,
  input wire logic                  cp_stall_o,
  input wire logic                  cp_done_o,
  input wire logic                  cp_undef_o,
  // Cache and TLB ports
  input wire logic                  cm_req_o,
  input wire cmx_pkg::cmx_op_type   cm_kind_o,
  input wire logic [31:0]           cm_addr_o,
  input wire logic [1:0]            cm_way_o,
  input wire logic [8:0]            cm_set_o,
  input wire logic                  cm_last_i,
  input wire logic                  tlb_req_o,
  input wire logic [31:0]           tlb_va_o,
  input wire logic [1:0]            tlb_perm_o,
  input wire logic [7:0]            tlb_address_space_id_o,
  input wire logic                  tlb_done_i
);
  // ==========================================
  // Helpers
  logic       take;
  logic [8:0] smask;
  assign take  = cp_valid_i && !cp_stall_o && cp_crn_i == 4'h7;
  assign smask = 9'h1ff >> (2'h2 - cache_size_i);

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ==========================================
  // Properties
  user_trap_a: assert property (
    take && cp_user_i && cp_crm_i inside {4'h6, 4'h8, 4'he} |=> cp_undef_o && !cp_done_o)
    else $error("user op not trapped");
  priv_ok_a: assert property (
    take && !cp_user_i && cp_crm_i inside {4'h6, 4'ha, 4'he} && cp_op2_i <= 3'h2
    |=> !cp_undef_o) else $error("privileged op trapped");
  line_addr_a: assert property (
    cm_req_o && cm_kind_o == cmx_pkg::OPK_LINE_MVA |-> cm_addr_o[4:0] == 5'h00)
    else $error("line address low bits kept");
  btc_addr_a: assert property (
    cm_req_o && cm_kind_o == cmx_pkg::OPK_BTC_ONE |-> cm_addr_o[2:0] == 3'h0)
    else $error("entry address low bits kept");
  way_field_a: assert property (
    cm_req_o && cm_kind_o == cmx_pkg::OPK_LINE_SW |-> cm_way_o == cm_addr_o[31:30])
    else $error("way field wrong");
  set_field_a: assert property (
    cm_req_o && cm_kind_o == cmx_pkg::OPK_LINE_SW |-> cm_set_o == (cm_addr_o[13:5] & smask))
    else $error("set field wrong");
  xlate_start_a: assert property (
    take && cp_write_i && !cp_user_i && cp_crm_i == 4'h8 && cp_op2_i <= 3'h3
    |=> cp_stall_o ##1 tlb_req_o && tlb_perm_o == $past(cp_op2_i[1:0], 2)
        && tlb_va_o == $past(cp_wdata_i, 2)) else $error("translation launch wrong");
  xlate_end_a: assert property (
    tlb_req_o && tlb_done_i |=> !tlb_req_o ##1 cp_done_o && !cp_stall_o)
    else $error("translation end wrong");
  space_id_a: assert property (
    tlb_req_o |-> tlb_address_space_id_o == address_space_id_i && cp_stall_o)
    else $error("lookup space id wrong");
  whole_done_a: assert property (
    cm_req_o && cm_kind_o == cmx_pkg::OPK_WHOLE && cm_last_i |=> cp_done_o)
    else $error("whole op not finished");
endmodule // cmx_props

bind cmx_top cmx_props cmx_props_inst (.*);

//--- dv/cmx_far_model.sv
// Model: TLB and cache responders
`timescale 1ns/1ns
module cmx_far_model (
  // Clock, reset and pacing
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic [3:0]          tlb_dly_i,
  input  wire logic [10:0]         walk_len_i,
  // Requests
  input  wire logic                tlb_req_i,
  input  wire logic [31:0]         tlb_va_i,
  input  wire logic                cm_req_i,
  input  wire cmx_pkg::cmx_op_type cm_kind_i,
  input  wire logic [10:0]         cm_pos_i,
  // Answers
  output logic                     tlb_done_o,
  output logic                     tlb_abort_o,
  output logic [4:0]               tlb_fault_o,
  output logic [19:0]              tlb_page_o,
  output logic                     tlb_share_o,
  output logic [1:0]               tlb_type_o,
  output logic [1:0]               tlb_inner_o,
  output logic [1:0]               tlb_outer_o,
  output logic                     cm_hit_o,
  output logic                     cm_last_o
);
  logic [3:0]  cnt;
  logic [31:0] v;
  // Junk outside the done cycle
  assign v           = tlb_done_o ? tlb_va_i : ~tlb_va_i;
  assign tlb_abort_o = v[11];
  assign tlb_fault_o = v[10:6];
  assign tlb_page_o  = ~v[31:12];
  assign tlb_share_o = v[0];
  assign tlb_type_o  = v[2:1];
  assign tlb_inner_o = v[4:3];
  assign tlb_outer_o = v[6:5];
  assign cm_hit_o    = 1'b0;

  // Resumed walks end early
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt        <= 4'h0;
      tlb_done_o <= 1'b0;
      cm_last_o  <= 1'b0;
    end else begin
      tlb_done_o <= tlb_req_i && !tlb_done_o && cnt == tlb_dly_i;
      cnt        <= (tlb_req_i && !tlb_done_o) ? cnt + 4'h1 : 4'h0;
      cm_last_o  <= cm_req_i && cm_kind_i == cmx_pkg::OPK_WHOLE
                    && cm_pos_i == walk_len_i && !cm_last_o;
    end
  end
endmodule // cmx_far_model

//--- dv/cmx_top_test.sv
// Testbench: directed scenarios for the top
`timescale 1ns/1ns
module cmx_top_test;
  logic                  clk_i = 1'b0;
  logic                  rst_i = 1'b1;
  cmx_pkg::cmx_size_type cache_size_i = cmx_pkg::CSZ_16K;
  logic [7:0]            address_space_id_i = 8'h5a;
  logic                  cp_valid_i = 1'b0, cp_write_i = 1'b0, cp_user_i = 1'b0;
  logic                  irq_take_i = 1'b0;
  logic [3:0]            cp_crn_i = 4'h7, cp_crm_i = 4'h0, tlb_dly = 4'h0;
  logic [2:0]            cp_op2_i = 3'h0;
  logic [31:0]           cp_wdata_i = 32'h0, cp_pc_i = 32'h0000_8000;
  logic [10:0]           walk_len = 11'd40, cm_pos_o;
  logic                  cp_stall_o, cp_done_o, cp_undef_o, cm_req_o, cm_hit_i, cm_last_i;
  logic                  tlb_req_o, tlb_done_i, tlb_abort_i, tlb_share_i;
  logic [31:0]           cp_rdata_o, irq_link_o, cm_addr_o, tlb_va_o, cap_addr, rdata;
  logic [1:0]            cm_way_o, tlb_perm_o, tlb_type_i, tlb_inner_i, tlb_outer_i;
  logic [1:0]            cap_way, cap_perm;
  logic [8:0]            cm_set_o, cap_set;
  logic [3:0]            cm_crm_o;
  logic [7:0]            tlb_address_space_id_o, cap_address_space_id;
  logic [4:0]            tlb_fault_i;
  logic [19:0]           tlb_page_i;
  logic                  got_done, got_undef;
  cmx_pkg::cmx_op_type   cm_kind_o, cap_kind;
  int                    bad_count = 0, n_compared = 0, n_tlb = 0, last_n;

  cmx_top cmx_top_inst (.*);
  cmx_far_model cmx_far_model_inst (.clk_i(clk_i), .rst_i(rst_i), .tlb_dly_i(tlb_dly),
    .walk_len_i(walk_len), .tlb_req_i(tlb_req_o), .tlb_va_i(tlb_va_o), .cm_req_i(cm_req_o),
    .cm_kind_i(cm_kind_o), .cm_pos_i(cm_pos_o), .tlb_done_o(tlb_done_i),
    .tlb_abort_o(tlb_abort_i), .tlb_fault_o(tlb_fault_i), .tlb_page_o(tlb_page_i),
    .tlb_share_o(tlb_share_i), .tlb_type_o(tlb_type_i), .tlb_inner_o(tlb_inner_i),
    .tlb_outer_o(tlb_outer_i), .cm_hit_o(cm_hit_i), .cm_last_o(cm_last_i));

  always #25 clk_i = ~clk_i;

  // Last far requests
  always @(posedge clk_i) begin
    if (cm_req_o) begin
      cap_addr = cm_addr_o;
      cap_way  = cm_way_o;
      cap_set  = cm_set_o;
      cap_kind = cm_kind_o;
    end
    if (tlb_req_o) begin
      cap_perm = tlb_perm_o;
      cap_address_space_id = tlb_address_space_id_o;
      n_tlb++;
    end
  end

  // ==========================================
  // Shared tasks
  task automatic chk(input logic [31:0] g, e, input string m);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("Error at %0t: %s got %h expected %h", $time, m, g, e);
    end
  endtask

  // One instruction, then one idle edge
  task automatic cp_op(input logic wr, usr, input logic [3:0] crm, input logic [2:0] op2,
                       input logic [31:0] d);
    {cp_write_i, cp_user_i, cp_crm_i, cp_op2_i, cp_wdata_i} = {wr, usr, crm, op2, d};
    cp_valid_i = 1'b1;
    last_n = 0;
    do begin
      @(posedge clk_i);
      #5;
      cp_valid_i = 1'b0;
      last_n++;
    end while (!(cp_done_o === 1'b1 || cp_undef_o === 1'b1) && last_n < 400);
    if (last_n >= 400) chk(32'h0, 32'h1, "no completion");
    {got_done, got_undef, rdata} = {cp_done_o, cp_undef_o, cp_rdata_o};
    @(posedge clk_i);
    #5;
  endtask

  function automatic logic [31:0] xl_exp(input logic [31:0] v);
    if (v[11]) return {26'h0, v[10:6], 1'b1};
    return {~v[31:12], 3'h0, v[0], v[2:1], (v[2:1] == 2'h2) ? {v[4:3], v[6:5]} : 4'h0, 2'h0};
  endfunction

  // ==========================================
  // Scenarios
  task automatic t_setway;
    for (int i = 0; i < 3; i++) begin
      cache_size_i = cmx_pkg::cmx_size_type'(i);
      cp_op(1'b1, 1'b0, 4'ha, 3'h2, 32'hbfff_ffff);
      chk(32'(cap_way), 32'h2, "way");
      chk(32'(cap_set), 32'h1ff >> (2 - i), "set");
    end
    cp_op(1'b1, 1'b0, 4'h6, 3'h2, 32'h4000_0020);
    chk({cap_way, cap_set}, {2'h1, 9'h001}, "way and set");
  endtask

  task automatic t_line;
    logic [3:0] crms [4] = '{4'h5, 4'h6, 4'ha, 4'he};
    foreach (crms[i]) begin
      cp_op(1'b1, 1'b0, crms[i], 3'h1, 32'h1234_567f);
      chk({cap_kind, cap_addr[28:0]}, {cmx_pkg::OPK_LINE_MVA, 29'h1234_5660}, "line");
      chk(32'(got_done), 32'h1, "line done");
    end
    cp_op(1'b1, 1'b0, 4'h5, 3'h7, 32'h1234_567f);
    chk({cap_kind, cap_addr[28:0]}, {cmx_pkg::OPK_BTC_ONE, 29'h1234_5678}, "entry");
  endtask

  task automatic t_user;
    int n0;
    n0 = n_tlb;
    cp_op(1'b1, 1'b1, 4'h8, 3'h0, 32'h0000_1000);
    chk(32'(got_undef), 32'h1, "user translate");
    cp_op(1'b0, 1'b1, 4'h4, 3'h0, 32'h0);
    chk(32'(got_undef), 32'h1, "user result read");
    cp_op(1'b1, 1'b1, 4'he, 3'h1, 32'h0);
    chk(32'(got_undef), 32'h1, "user line op");
    cp_op(1'b1, 1'b1, 4'ha, 3'h5, 32'h0);
    chk(32'(got_undef), 32'h0, "user barrier");
    chk(32'(n_tlb), 32'(n0), "user lookups");
  endtask

  task automatic t_xlate;
    logic [31:0] vas [5] = '{32'h1234_5075, 32'habcd_e003, 32'h0000_0018,
                             32'h7777_7c40, 32'hfedc_b0f5};
    cp_op(1'b0, 1'b0, 4'h4, 3'h0, 32'h0);
    chk(rdata, 32'h0, "result at reset");
    foreach (vas[i]) begin
      tlb_dly = 4'(i * 3);
      address_space_id_i = 8'(8'h10 + i);
      cp_op(1'b1, 1'b0, 4'h8, 3'(i % 4), vas[i]);
      chk(32'(cap_perm), i % 4, "permission kind");
      chk(32'(cap_address_space_id), 32'(address_space_id_i), "space id");
      cp_op(1'b0, 1'b0, 4'h4, 3'h0, 32'h0);
      chk(rdata, xl_exp(vas[i]), "result word");
    end
  endtask

  task automatic t_whole;
    logic [3:0] crms [4] = '{4'h5, 4'h6, 4'h7, 4'he};
    {cp_write_i, cp_crm_i, cp_op2_i, cp_valid_i} = {1'b1, 4'ha, 3'h0, 1'b1};
    @(posedge clk_i);
    #5;
    cp_valid_i = 1'b0;
    repeat (10) @(posedge clk_i);
    #5;
    irq_take_i = 1'b1;
    @(posedge clk_i);
    #5;
    irq_take_i = 1'b0;
    repeat (2) @(posedge clk_i);
    #5;
    chk(irq_link_o, 32'h0000_8004, "return link");
    chk(32'(cp_stall_o), 32'h0, "stall after abandon");
    cp_op(1'b1, 1'b0, 4'ha, 3'h0, 32'h0);
    chk(32'(last_n < 36), 32'h1, "resumed walk");
    foreach (crms[i]) begin
      cp_op(1'b1, 1'b0, crms[i], 3'h0, 32'h0);
      chk(32'(got_done && last_n > 38), 32'h1, "fresh walk");
    end
  endtask

  // ==========================================
  // Sequence and verdict
  task end_of_test;
    $display("Comparisons %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk_i);
    #5;
    rst_i = 1'b0;
    t_setway();
    t_line();
    t_user();
    t_xlate();
    t_whole();
    end_of_test();
  end

  initial begin
    #1000000;
    bad_count++;
    end_of_test();
  end
endmodule // cmx_top_test
